//--- sesc_host.sv
// SPI host model that also services the watchdog
`default_nettype none

module sesc_host (
  input wire logic so_o,
  input wire logic so_oe,
  output logic sck,
  output logic si,
  output logic sel_n
);
  timeunit 1ns;
  timeprecision 1ps;

  int pause_at = -1;

  initial begin
    sck = 1'b0;
    si = 1'b0;
    sel_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////
  // Whole sequence under one select-low period, clock idles low
  task automatic frame(input int n, input logic [39:0] tx, output logic [39:0] rx);
    rx = '0;
    sel_n = 1'b0;
    #400;
    for (int i = n - 1; i >= 0; i--) begin
      si = tx[i]; // Msb first
      #200;
      sck = 1'b1;
      #200;
      // Sample late in the high phase, output lags the pin by sync delay
      rx = {rx[38:0], so_oe ? so_o : 1'bz};
      sck = 1'b0;
      if (i == pause_at) begin // Slow host stalls with clock low
        #3000;
      end
    end
    #200;
    sel_n = 1'b1;
    // Released line must not keep the last bit
    si = ~si;
    #400;
  endtask

  // Bare select pulse, no clocks
  task automatic kick();
    sel_n = 1'b0;
    #200;
    sel_n = 1'b1;
    #200;
  endtask
endmodule

`default_nettype wire

//--- sesc_pkg.sv
// Shared constants and types of the supervisor control block
`default_nettype none

package sesc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timebase
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned RST_T_MS = 200;
  localparam int unsigned RST_CYC = RST_T_MS * CYC_PER_MS;
  localparam int unsigned WD0_T_MS = 1400;
  localparam int unsigned WD1_T_MS = 600;
  localparam int unsigned WD2_T_MS = 200;
  localparam int unsigned WD0_CYC = WD0_T_MS * CYC_PER_MS;
  localparam int unsigned WD1_CYC = WD1_T_MS * CYC_PER_MS;
  localparam int unsigned WD2_CYC = WD2_T_MS * CYC_PER_MS;
  // Self-timed write length, modelled only
  localparam int unsigned WR_T_US = 4000;
  localparam int unsigned WR_CYC = WR_T_US * CYC_PER_US;

  ////////////////////////////////////////////////////////////////////////////
  // Opcodes
  localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
  localparam logic [7:0] SET_FLAG_CMD = 8'h00;
  localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0] READ_STATUS_CMD = 8'h05;
  localparam logic [7:0] WRITE_STATUS_CMD = 8'h01;
  localparam logic [7:0] READ_ARRAY_CMD = 8'h03;
  localparam logic [7:0] WRITE_ARRAY_CMD = 8'h02;

  ////////////////////////////////////////////////////////////////////////////
  // Status byte layout
  localparam int SB_GUARD = 7;
  localparam int SB_FLAG = 6;
  localparam int SB_WD_HI = 5;
  localparam int SB_WD_LO = 4;
  localparam int SB_BL_HI = 3;
  localparam int SB_BL_LO = 2;

  localparam logic [1:0] WD_OFF = 2'h3;
  localparam logic [1:0] WD_P0 = 2'h0;
  localparam logic [1:0] WD_P1 = 2'h1;
  localparam logic [1:0] BL_NONE = 2'h0;
  localparam logic [1:0] BL_QTR = 2'h1;
  localparam logic [1:0] BL_HALF = 2'h2;

  // Nonvolatile bits as loaded on every reset
  localparam logic NV_GUARD_INIT = 1'h0;
  localparam logic [1:0] NV_WD_INIT = 2'h0;
  localparam logic [1:0] NV_BL_INIT = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Array geometry
  localparam int ARR_AW = 13;
  localparam int ARR_DEPTH = 8192;
  localparam int PAGE_AW = 5;
  localparam int PAGE_DEPTH = 32;
  localparam logic [1:0] QTR_TOP = 2'h3;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [3:0] ADDR_LAST = 4'hf;

  typedef enum logic [3:0] {
    ST_IDLE, ST_OPC, ST_ADDR, ST_RDATA, ST_WDATA, ST_SRD, ST_SWR, ST_SWDONE,
    ST_CMDDONE, ST_IGNORE
  } sesc_state_t;

endpackage

`default_nettype wire

//--- sesc_sync.sv
// Two-flop synchroniser for one pin input
`default_nettype none

module sesc_sync #(
  parameter logic RST_VAL = 1'h0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);

  logic meta_q;

  // First flop feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

`default_nettype wire

//--- sesc_top.sv
// Supervisor with serial memory: decoder, status, protection, watchdog, reset
`default_nettype none

module sesc_top #(
  parameter int unsigned RST_HOLD = sesc_pkg::RST_CYC,
  parameter int unsigned WD_LIM0 = sesc_pkg::WD0_CYC,
  parameter int unsigned WD_LIM1 = sesc_pkg::WD1_CYC,
  parameter int unsigned WD_LIM2 = sesc_pkg::WD2_CYC,
  parameter int unsigned WR_CYCLES = sesc_pkg::WR_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic si,
  input wire logic select_kick_pin_n,
  input wire logic wp_n,
  input wire logic vcc_ok,
  output logic so_o,
  output logic so_oe,
  output logic reset_pin_o,
  output logic reset_pin_oe
);
  import sesc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic sck_s, si_s, cs_s, wp_s, vcc_s;

  sesc_sync #(.RST_VAL(1'h0)) u_sck (.clk(clk), .rst_n(rst_n), .d(sck), .q(sck_s));
  sesc_sync #(.RST_VAL(1'h0)) u_si (.clk(clk), .rst_n(rst_n), .d(si), .q(si_s));
  sesc_sync #(.RST_VAL(1'h1)) u_cs (.clk(clk), .rst_n(rst_n), .d(select_kick_pin_n),
    .q(cs_s));
  sesc_sync #(.RST_VAL(1'h1)) u_wp (.clk(clk), .rst_n(rst_n), .d(wp_n), .q(wp_s));
  sesc_sync #(.RST_VAL(1'h0)) u_vcc (.clk(clk), .rst_n(rst_n), .d(vcc_ok), .q(vcc_s));

  ////////////////////////////////////////////////////////////////////////////
  // Serial engine state
  sesc_state_t st_q, st_d;
  logic sck_p_q, sck_p_d, cs_p_q, cs_p_d;
  logic [2:0] bcnt_q, bcnt_d;
  logic [3:0] acnt_q, acnt_d;
  logic [7:0] sr_q, sr_d, op_q, op_d, out_q, out_d;
  logic [15:0] addr_q, addr_d;
  logic so_q, so_d, so_oe_q, so_oe_d;
  logic write_latch_q, write_latch_d, reset_cause_flag_q, reset_cause_flag_d;
  logic guard_enable_q, guard_enable_d;
  logic [1:0] wdog_period_q, wdog_period_d, protect_range_q, protect_range_d;
  logic [31:0] busy_cnt_q, busy_cnt_d;
  logic [PAGE_DEPTH-1:0] pmask_q, pmask_d;
  logic commit, pbuf_we;

  logic [7:0] mem [0:ARR_DEPTH-1];
  logic [7:0] pbuf [0:PAGE_DEPTH-1];

  logic sck_rise, sck_fall, cs_rise, cs_fall, busy;
  logic [7:0] in_byte, status, rd_load, rd_next;
  logic [15:0] addr_shift, addr_inc;

  assign sck_rise = sck_s & ~sck_p_q;
  assign sck_fall = ~sck_s & sck_p_q;
  assign cs_rise = cs_s & ~cs_p_q;
  assign cs_fall = ~cs_s & cs_p_q;
  assign busy = (busy_cnt_q != 32'h0);
  assign in_byte = {sr_q[6:0], si_s};
  assign addr_shift = {addr_q[14:0], si_s};
  assign addr_inc = addr_q + 16'h1;
  assign rd_load = mem[addr_shift[ARR_AW-1:0]];
  assign rd_next = mem[addr_inc[ARR_AW-1:0]];
  assign status = {guard_enable_q, reset_cause_flag_q, wdog_period_q, protect_range_q,
    write_latch_q, busy};

  // Protected range test on the top array address bits
  function automatic logic in_prot(input logic [ARR_AW-1:0] a, input logic [1:0] rng);
    logic hit;
    case (rng)
      BL_NONE: hit = 1'b0;
      BL_QTR: hit = (a[ARR_AW-1:ARR_AW-2] == QTR_TOP);
      BL_HALF: hit = a[ARR_AW-1];
      default: hit = 1'b1;
    endcase
    return hit;
  endfunction

  always_comb begin
    st_d = st_q;
    sck_p_d = sck_s;
    cs_p_d = cs_s;
    bcnt_d = bcnt_q;
    acnt_d = acnt_q;
    sr_d = sr_q;
    op_d = op_q;
    out_d = out_q;
    addr_d = addr_q;
    so_d = so_q;
    so_oe_d = ~cs_s;
    write_latch_d = write_latch_q;
    reset_cause_flag_d = reset_cause_flag_q;
    guard_enable_d = guard_enable_q;
    wdog_period_d = wdog_period_q;
    protect_range_d = protect_range_q;
    busy_cnt_d = busy_cnt_q;
    pmask_d = pmask_q;
    commit = 1'b0;
    pbuf_we = 1'b0;
    if (busy) begin
      busy_cnt_d = busy_cnt_q - 32'h1;
      if (busy_cnt_q == 32'h1) begin
        write_latch_d = 1'b0;
      end
    end
    if (cs_s) begin
      // Deselect: only now do completed instructions take effect
      if (cs_rise) begin
        case (st_q)
          ST_CMDDONE: begin
            if (op_q == SET_WRITE_LATCH_CMD) begin
              write_latch_d = 1'b1;
            end else if (op_q == SET_FLAG_CMD) begin
              reset_cause_flag_d = 1'b1;
            end else begin
              write_latch_d = 1'b0;
              reset_cause_flag_d = 1'b0;
            end
          end
          ST_SWDONE: begin
            guard_enable_d = sr_q[SB_GUARD];
            reset_cause_flag_d = sr_q[SB_FLAG];
            wdog_period_d = sr_q[SB_WD_HI:SB_WD_LO];
            protect_range_d = sr_q[SB_BL_HI:SB_BL_LO];
            busy_cnt_d = WR_CYCLES;
          end
          ST_WDATA: begin
            if ((bcnt_q == 3'h0) && (pmask_q != '0)) begin
              commit = 1'b1;
              busy_cnt_d = WR_CYCLES;
            end
          end
          default: begin
          end
        endcase
      end
      st_d = ST_IDLE;
    end else if (cs_fall) begin
      st_d = ST_OPC;
      bcnt_d = 3'h0;
    end else if (sck_rise) begin
      // Pauses of the serial clock leave the bit and address counters untouched
      case (st_q)
        ST_OPC: begin
          sr_d = in_byte;
          bcnt_d = bcnt_q + 3'h1;
          if (bcnt_q == BIT_LAST) begin
            op_d = in_byte;
            acnt_d = 4'h0;
            if (busy && (in_byte != READ_STATUS_CMD)) begin
              st_d = ST_IGNORE;
            end else begin
              case (in_byte)
                READ_STATUS_CMD: begin
                  st_d = ST_SRD;
                  out_d = status;
                end
                SET_WRITE_LATCH_CMD, SET_FLAG_CMD, CLEAR_WRITE_LATCH_CMD: st_d = ST_CMDDONE;
                WRITE_STATUS_CMD: begin
                  if (write_latch_q && !(guard_enable_q && !wp_s)) begin
                    st_d = ST_SWR;
                  end else begin
                    st_d = ST_IGNORE;
                  end
                end
                READ_ARRAY_CMD: st_d = ST_ADDR;
                WRITE_ARRAY_CMD: begin
                  pmask_d = '0;
                  st_d = write_latch_q ? ST_ADDR : ST_IGNORE;
                end
                default: st_d = ST_IGNORE;
              endcase
            end
          end
        end
        ST_ADDR: begin
          addr_d = addr_shift;
          acnt_d = acnt_q + 4'h1;
          if (acnt_q == ADDR_LAST) begin
            bcnt_d = 3'h0;
            if (op_q == READ_ARRAY_CMD) begin
              st_d = ST_RDATA;
              out_d = rd_load;
            end else begin
              st_d = ST_WDATA;
            end
          end
        end
        ST_WDATA: begin
          sr_d = in_byte;
          bcnt_d = bcnt_q + 3'h1;
          if (bcnt_q == BIT_LAST) begin
            pbuf_we = 1'b1;
            pmask_d[addr_q[PAGE_AW-1:0]] = 1'b1;
            // Address wraps inside the page
            addr_d[PAGE_AW-1:0] = addr_q[PAGE_AW-1:0] + 5'h1;
          end
        end
        ST_SWR: begin
          sr_d = in_byte;
          bcnt_d = bcnt_q + 3'h1;
          if (bcnt_q == BIT_LAST) begin
            st_d = ST_SWDONE;
          end
        end
        ST_CMDDONE, ST_SWDONE: st_d = ST_IGNORE;
        default: begin
        end
      endcase
    end else if (sck_fall && ((st_q == ST_RDATA) || (st_q == ST_SRD))) begin
      so_d = out_q[7];
      out_d = {out_q[6:0], 1'b0};
      bcnt_d = bcnt_q + 3'h1;
      if (bcnt_q == BIT_LAST) begin
        if (st_q == ST_RDATA) begin
          addr_d = addr_inc;
          out_d = rd_next;
        end else begin
          out_d = status;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      sck_p_q <= 1'b0;
      cs_p_q <= 1'b1;
      bcnt_q <= 3'h0;
      acnt_q <= 4'h0;
      sr_q <= 8'h00;
      op_q <= 8'h00;
      out_q <= 8'h00;
      addr_q <= 16'h0000;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
      write_latch_q <= 1'b0;
      reset_cause_flag_q <= 1'b0;
      guard_enable_q <= NV_GUARD_INIT;
      wdog_period_q <= NV_WD_INIT;
      protect_range_q <= NV_BL_INIT;
      busy_cnt_q <= 32'h0;
      pmask_q <= '0;
    end else begin
      st_q <= st_d;
      sck_p_q <= sck_p_d;
      cs_p_q <= cs_p_d;
      bcnt_q <= bcnt_d;
      acnt_q <= acnt_d;
      sr_q <= sr_d;
      op_q <= op_d;
      out_q <= out_d;
      addr_q <= addr_d;
      so_q <= so_d;
      so_oe_q <= so_oe_d;
      write_latch_q <= write_latch_d;
      reset_cause_flag_q <= reset_cause_flag_d;
      guard_enable_q <= guard_enable_d;
      wdog_period_q <= wdog_period_d;
      protect_range_q <= protect_range_d;
      busy_cnt_q <= busy_cnt_d;
      pmask_q <= pmask_d;
    end
  end

  // Array and page buffer carry no reset: cell contents survive power-up
  always_ff @(posedge clk) begin
    if (pbuf_we) begin
      pbuf[addr_q[PAGE_AW-1:0]] <= in_byte;
    end
    if (commit) begin
      for (int i = 0; i < PAGE_DEPTH; i++) begin
        if (pmask_q[i] && !in_prot({addr_q[ARR_AW-1:PAGE_AW], 5'(i)}, protect_range_q)) begin
          mem[{addr_q[ARR_AW-1:PAGE_AW], 5'(i)}] <= pbuf[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supply monitor, reset stretch and watchdog
  logic [31:0] hold_cnt_q, hold_cnt_d, wd_cnt_q, wd_cnt_d, wd_lim;
  logic rst_act_q, rst_act_d, rst_pin_q;

  always_comb begin
    case (wdog_period_q)
      WD_P0: wd_lim = WD_LIM0;
      WD_P1: wd_lim = WD_LIM1;
      default: wd_lim = WD_LIM2;
    endcase
    hold_cnt_d = hold_cnt_q;
    wd_cnt_d = wd_cnt_q + 32'h1;
    if (!vcc_s) begin
      hold_cnt_d = 32'h0;
    end else if (hold_cnt_q < RST_HOLD) begin
      hold_cnt_d = hold_cnt_q + 32'h1;
    end
    if (rst_act_q || (wdog_period_q == WD_OFF) || cs_fall) begin
      wd_cnt_d = 32'h0;
    end else if (wd_cnt_q >= wd_lim - 32'h1) begin
      wd_cnt_d = 32'h0;
      hold_cnt_d = 32'h0;
    end
    rst_act_d = (hold_cnt_d < RST_HOLD);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt_q <= 32'h0;
      wd_cnt_q <= 32'h0;
      rst_act_q <= 1'b1;
      rst_pin_q <= 1'b0;
    end else begin
      hold_cnt_q <= hold_cnt_d;
      wd_cnt_q <= wd_cnt_d;
      rst_act_q <= rst_act_d;
      rst_pin_q <= 1'b0;
    end
  end

  assign so_o = so_q;
  assign so_oe = so_oe_q;
  assign reset_pin_o = rst_pin_q;
  assign reset_pin_oe = rst_act_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_LOW_SUPPLY_RESET: assert property (!vcc_s |=> reset_pin_oe)
    else $error("reset not asserted on low supply");
  AST_RESET_STRETCH: assert property ($rose(vcc_s) |=> reset_pin_oe [*8])
    else $error("reset released too early");
  AST_SO_UNDRIVEN: assert property (cs_s |=> !so_oe)
    else $error("output driven while deselected");
  AST_SO_ON_FALL: assert property ($changed(so_o) |-> $past(sck_fall))
    else $error("output changed outside falling edge");
  AST_LATCH_GATES_WRITE: assert property (st_q == ST_OPC && sck_rise
    && bcnt_q == BIT_LAST && in_byte == WRITE_ARRAY_CMD && !write_latch_q && !busy
    |=> st_q == ST_IGNORE)
    else $error("array write accepted with latch clear");
  AST_GUARD_LOCK: assert property (st_q == ST_OPC && sck_rise && bcnt_q == BIT_LAST
    && in_byte == WRITE_STATUS_CMD && guard_enable_q && !wp_s |=> st_q != ST_SWR)
    else $error("status write accepted while locked");
  AST_BUSY_AFTER_COMMIT: assert property (commit |=> busy ##1 busy)
    else $error("busy not set by write start");
  AST_LATCH_CLEARED: assert property ($fell(busy) |-> !write_latch_q)
    else $error("latch still set after write cycle");
  AST_KICK_RESTARTS: assert property (cs_fall && !rst_act_q |=> wd_cnt_q == 32'h0)
    else $error("kick did not restart watchdog");
  AST_BUSY_BLOCKS: assert property (busy && st_q == ST_OPC && sck_rise
    && bcnt_q == BIT_LAST && in_byte != READ_STATUS_CMD |=> st_q == ST_IGNORE)
    else $error("command honoured during write cycle");

  COV_ARRAY_COMMIT: cover property (commit);
  COV_STATUS_READ: cover property (st_q == ST_SRD && busy);
  COV_WDOG_EXPIRE: cover property (!rst_act_q ##1 rst_act_q && vcc_s);
  COV_SEQ_READ: cover property (st_q == ST_RDATA && sck_fall && bcnt_q == BIT_LAST);

endmodule

`default_nettype wire

//--- test_sesc_top.sv
// Self-checking bench of the supervisor control block
`default_nettype none

module test_sesc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sesc_pkg::*;

  // Shortened counts keep the run short
  localparam int RH = 40;
  localparam int WRC = 400;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n = 1'b1;
  logic vcc_ok = 1'b1;
  logic sck;
  logic si;
  logic sel_n;
  logic so_o;
  logic so_oe;
  logic rp_o;
  logic rp_oe;
  // Open drain with pull-up
  wire rst_line = rp_oe ? rp_o : 1'b1;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int k;
  logic [39:0] rx;
  logic [7:0] s;
  logic [1:0] bl = 2'h0;
  logic [7:0] mem [int];
  logic [15:0] al [6] = '{16'h0000, 16'h0fff, 16'h1000, 16'h17ff, 16'h1800, 16'h1fff};

  always #25 clk = ~clk;

  sesc_top #(.RST_HOLD(RH), .WD_LIM0(2800), .WD_LIM1(1200), .WD_LIM2(400),
    .WR_CYCLES(WRC)) dut (.clk(clk), .rst_n(rst_n), .sck(sck), .si(si),
    .select_kick_pin_n(sel_n), .wp_n(wp_n), .vcc_ok(vcc_ok), .so_o(so_o),
    .so_oe(so_oe), .reset_pin_o(rp_o), .reset_pin_oe(rp_oe));

  sesc_host host (.so_o(so_o), .so_oe(so_oe), .sck(sck), .si(si), .sel_n(sel_n));

  ////////////////////////////////////////////////////////////
  function automatic int lim(input logic [1:0] c);
    return c == 2'h0 ? 2800 : c == 2'h1 ? 1200 : c == 2'h2 ? 400 : 3000;
  endfunction

  function automatic logic prot(input logic [1:0] b, input logic [15:0] a);
    return b == 2'h3 || (b == 2'h2 && a[12]) || (b == 2'h1 && a[12:11] == 2'h3);
  endfunction

  task automatic conclude();
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t byte %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t bit %b exp %b", $time, got, exp);
    end
  endtask

  // Lets the edge's own updates land before anything is looked at
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic op(input int n, input logic [39:0] v);
    host.pause_at = ($urandom % 4 == 0) ? int'($urandom % n) : -1;
    host.frame(n, v, rx);
  endtask

  task automatic read_status_cmd();
    op(16, {READ_STATUS_CMD, 8'h00});
    s = rx[7:0];
  endtask

  task automatic wen();
    op(8, SET_WRITE_LATCH_CMD);
  endtask

  task automatic idle();
    for (int i = 0; i < 30; i++) begin
      read_status_cmd();
      if (s[0] === 1'b0) break;
    end
    chk1(s[0], 1'b0);
  endtask

  task automatic write_status_cmd(input logic [7:0] v);
    wen();
    op(16, {WRITE_STATUS_CMD, v});
    idle();
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    wen();
    op(32, {WRITE_ARRAY_CMD, a, d});
    idle();
    if (!prot(bl, a)) mem[a] = d;
  endtask

  task automatic rd(input logic [15:0] a);
    op(40, {READ_ARRAY_CMD, a, 16'h0000});
    chk8(rx[15:8], mem[a]);
    if (mem.exists(a + 1)) chk8(rx[7:0], mem[a + 1]);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      $display("mismatch t=%0t timeout", $time);
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(34552));
    tick(16);
    chk1(rst_line, 1'b0);
    chk1(so_oe, 1'b0);
    rst_n = 1'b1;
    tick(RH - 1);
    chk1(rst_line, 1'b0);
    tick(12);
    chk1(rst_line, 1'b1);
    $display("test power-up done");
    read_status_cmd();
    chk8(s, 8'h00);
    op(8, SET_FLAG_CMD);
    read_status_cmd();
    chk8(s, 8'h40);
    wen();
    read_status_cmd();
    chk8(s, 8'h42);
    op(8, CLEAR_WRITE_LATCH_CMD);
    read_status_cmd();
    chk8(s, 8'h00);
    // A ninth clock spoils a one-byte command
    op(9, {SET_FLAG_CMD, 1'b0});
    read_status_cmd();
    chk8(s, 8'h00);
    op(8, 8'hff);
    read_status_cmd();
    chk8(s, 8'h00);
    $display("test commands done");
    op(8, SET_FLAG_CMD);
    wen();
    op(16, {WRITE_STATUS_CMD, 8'h40});
    read_status_cmd();
    chk8(s, 8'h43);
    op(8, CLEAR_WRITE_LATCH_CMD);
    idle();
    chk8(s, 8'h40);
    op(8, CLEAR_WRITE_LATCH_CMD);
    $display("test busy done");
    write_status_cmd(8'h80);
    read_status_cmd();
    chk8(s & 8'hfc, 8'h80);
    wp_n = 1'b0;
    write_status_cmd(8'h8c);
    read_status_cmd();
    chk8(s & 8'hfc, 8'h80);
    wp_n = 1'b1;
    write_status_cmd(8'h00);
    wp_n = 1'b0;
    write_status_cmd(8'h08);
    read_status_cmd();
    chk8(s & 8'hfc, 8'h08);
    wp_n = 1'b1;
    $display("test guard done");
    for (int b = 0; b < 4; b++) begin
      bl = 2'(b);
      write_status_cmd({4'h0, bl, 2'h0});
      foreach (al[j]) wr(al[j], 8'($urandom));
      foreach (al[j]) rd(al[j]);
    end
    bl = 2'h0;
    write_status_cmd(8'h00);
    wr(16'h0123, 8'ha5);
    op(32, {WRITE_ARRAY_CMD, 16'h0123, 8'h5a});
    idle();
    rd(16'h0123);
    wen();
    op(29, {WRITE_ARRAY_CMD, 16'h0123, 5'h1b});
    idle();
    rd(16'h0123);
    op(8, CLEAR_WRITE_LATCH_CMD);
    $display("test array done");
    for (int c = 0; c < 4; c++) begin
      write_status_cmd({2'h0, 2'(c), 4'h0});
      host.kick();
      tick(lim(2'(c)) / 2);
      // Count from the second kick: the first must be forgotten
      host.kick();
      k = 8;
      while (rp_oe !== 1'b1 && k < lim(2'(c)) + 40) begin
        tick(1);
        k++;
      end
      chk1(c == 3 ? k == 3040 : k >= lim(2'(c)) && k <= lim(2'(c)) + 10, 1'b1);
      tick(RH + 20);
      chk1(rst_line, 1'b1);
    end
    $display("test watchdog done");
    vcc_ok = 1'b0;
    tick(5);
    chk1(rst_line, 1'b0);
    tick(20);
    vcc_ok = 1'b1;
    tick(RH - 1);
    chk1(rst_line, 1'b0);
    tick(12);
    chk1(rst_line, 1'b1);
    op(8, SET_FLAG_CMD);
    wen();
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(RH + 12);
    read_status_cmd();
    chk8(s & 8'h43, 8'h00);
    $display("test supply done");
    conclude();
  end
endmodule

`default_nettype wire
